// ---- common/pwm_pkg.sv ----
package pwm_pkg;

	// -----------------------------------------------------------------
	// Register map, byte addresses on the APB bus.
	// -----------------------------------------------------------------
	localparam logic [7:0] CONFIGURE_OFFS  = 8'h00;
	localparam logic [7:0] CONTROL_OFFS    = 8'h04;
	localparam logic [7:0] SOURCE_OFFS     = 8'h08;
	localparam logic [7:0] MODULO_OFFS     = 8'h0c;
	localparam logic [7:0] DUTY_BASE_OFFS  = 8'h10;
	localparam logic [7:0] STATUS_OFFS     = 8'h28;
	localparam logic [7:0] LIMIT_OFFS      = 8'h2c;

	// Field positions in configure_reg.
	localparam int CFG_RUN_BIT    = 0;
	localparam int CFG_EDGE_BIT   = 1;
	localparam int CFG_INDEP_LSB  = 2;
	localparam int CFG_WAIT_BIT   = 5;
	localparam int CFG_DEBUG_BIT  = 6;
	localparam int CFG_FAST_BIT   = 7;

	// Field positions in the control register.
	localparam int CTL_LOAD_OKAY_BIT   = 0;
	localparam int CTL_PRSC_LSB   = 1;
	localparam int CTL_RATE_LSB   = 3;
	localparam int CTL_HALF_BIT   = 7;

	// Field positions in source_control_reg.
	localparam int SRC_INV_LSB    = 0;
	localparam int SRC_SEL_LSB    = 8;

	// Values after reset.
	localparam logic [7:0]  CONFIGURE_RST = 8'h00;
	localparam logic [14:0] MODULO_RST    = 15'h0000;
	localparam logic [15:0] LIMIT_LO_RST  = 16'h0000;
	localparam logic [15:0] LIMIT_HI_RST  = 16'hffff;

	// Operation clock is one third of the fast clock when not selected.
	localparam logic [1:0]  SLOW_DIV_LAST = 2'h2;

	// Drive source of one output pair.
	typedef enum logic [1:0] {
		SRC_GENERATOR = 2'b00,
		SRC_GPIO      = 2'b01,
		SRC_TIMER     = 2'b10,
		SRC_ADC       = 2'b11
	} pair_src_e;

	// APB request and answer.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	// Power mode requests from the system.
	typedef struct packed {
		logic stop;
		logic wait_mode;
		logic debug;
	} mode_req_s;

endpackage

// ---- core/pwm_tick_divider.sv ----
`timescale 1ns/10ps

// Counting clock enable: operation clock select then divide by 1, 2, 4 or 8.
module pwm_tick_divider
	import pwm_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	input  wire logic       fast_i,
	input  wire logic [1:0] prescale_i,
	output logic            tick_o
);

	typedef struct packed {
		logic [1:0] slow_cnt;
		logic [2:0] pre_cnt;
	} div_state_s;

	div_state_s st_q;
	div_state_s st_d;
	logic       op_en;
	logic [2:0] pre_last;

	// -----------------------------------------------------------------
	// Divider chain.
	// -----------------------------------------------------------------

	// Operation enable, then the prescaler on top of it.
	always_comb begin
		st_d     = st_q;
		pre_last = 3'((4'h1 << prescale_i) - 4'h1);
		op_en    = fast_i || (st_q.slow_cnt == SLOW_DIV_LAST);
		tick_o   = 1'b0;
		if (!run_i) begin
			st_d = '0;
		end else begin
			st_d.slow_cnt = (st_q.slow_cnt == SLOW_DIV_LAST) ? 2'h0 : st_q.slow_cnt + 2'h1;
			if (op_en) begin
				if (st_q.pre_cnt >= pre_last) begin
					st_d.pre_cnt = 3'h0;
					tick_o       = 1'b1;
				end else begin
					st_d.pre_cnt = st_q.pre_cnt + 3'h1;
				end
			end
		end
	end

	// State register.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule // pwm_tick_divider

// ---- core/pwm_six_channel.sv ----
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps

module pwm_six_channel
	import pwm_pkg::*;
#(
	parameter int CHANNELS = 6,
	parameter int PAIRS    = 3
) (
	input  wire logic                CLOCK_I,
	input  wire logic                RST_N_I,
	input  wire apb_req_s            APB_REQ_I,
	output apb_rsp_s                 APB_RSP_O,
	input  wire mode_req_s           MODE_I,
	input  wire logic [PAIRS-1:0]    PAIR_GPIO_I,
	input  wire logic [PAIRS-1:0]    TIMER_I,
	input  wire logic [15:0]         ADC_RESULT_I,
	input  wire logic                ADC_VALID_I,
	output logic [CHANNELS-1:0]      PWM_O,
	output logic                     SYNC_O
);

	// -----------------------------------------------------------------
	// State.
	// -----------------------------------------------------------------

	typedef struct packed {
		logic [7:0]                cfg;
		logic                      load_okay;
		logic [1:0]                prescale_buf;
		logic [1:0]                prescale_act;
		logic [3:0]                reload_rate;
		logic                      half_reload;
		logic [CHANNELS-1:0]       compare_invert;
		logic [2*PAIRS-1:0]        src_sel;
		logic [14:0]               mod_buf;
		logic [14:0]               mod_act;
		logic [CHANNELS-1:0][15:0] duty_buf;
		logic [CHANNELS-1:0][15:0] duty_act;
		logic [15:0]               lim_lo;
		logic [15:0]               lim_hi;
		logic [14:0]               cnt;
		logic                      down;
		logic [3:0]                reload_cnt;
		logic [PAIRS-1:0]          adc_drive;
		logic [PAIRS-1:0]          gpio_s1;
		logic [PAIRS-1:0]          gpio_s2;
		logic [CHANNELS-1:0]       pwm;
		logic                      sync;
		logic [31:0]               prdata;
	} pwm_state_s;

	pwm_state_s st_q;
	pwm_state_s st_d;

	logic                tick;
	logic                run;
	logic                edge_mode;
	logic                wr_en;
	logic                rd_setup;
	logic                mapped;
	logic                bypass_all;
	logic                period_end;
	logic                half_point;
	logic                reload;
	logic                hold_off;
	logic [14:0]         cnt_n;
	logic                down_n;
	logic [CHANNELS-1:0] cmp;
	logic [CHANNELS-1:0] drive;
	logic [PAIRS-1:0]    pair_src;
	logic [31:0]         rd_val;
	logic [4:0]          duty_idx;

	assign run       = st_q.cfg[CFG_RUN_BIT];
	assign edge_mode = st_q.cfg[CFG_EDGE_BIT];

	// -----------------------------------------------------------------
	// Counting clock enable.
	// -----------------------------------------------------------------

	// Only the active prescaler value reaches the divider.
	pwm_tick_divider u_div (
		.clk_i      (CLOCK_I),
		.rst_n_i    (RST_N_I),
		.run_i      (run),
		.fast_i     (st_q.cfg[CFG_FAST_BIT]),
		.prescale_i (st_q.prescale_act),
		.tick_o     (tick)
	);

	// -----------------------------------------------------------------
	// Helpers.
	// -----------------------------------------------------------------

	// Negative duty values count as zero.
	function automatic logic [15:0] clamp_duty(input logic [15:0] v);
		clamp_duty = v[15] ? 16'h0000 : v;
	endfunction

	// Compare output from the counter value it holds now.
	function automatic logic compare_out(input logic [15:0] duty, input logic [14:0] c,
			input logic dn, input logic edge_align_sel, input logic inv);
		logic [15:0] d;
		logic [15:0] cw;
		logic        act;
		d  = clamp_duty(duty);
		cw = {1'b0, c};
		if (edge_align_sel) begin
			act = (d != 16'h0000) && (cw <= d);
		end else if (dn) begin
			act = (cw <= d) && (d != 16'h0000);
		end else begin
			act = (cw < d);
		end
		compare_out = act ^ inv;
	endfunction

	// -----------------------------------------------------------------
	// Bus decode.
	// -----------------------------------------------------------------

	// Setup phase loads read data; access phase commits writes, zero wait.
	assign rd_setup = APB_REQ_I.psel && !APB_REQ_I.penable;
	assign wr_en    = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite;
	assign duty_idx = 5'((APB_REQ_I.paddr - DUTY_BASE_OFFS) >> 2);
	assign mapped   = (APB_REQ_I.paddr[1:0] == 2'b00) && (APB_REQ_I.paddr <= LIMIT_OFFS);

	// Read multiplexer.
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (APB_REQ_I.paddr)
			CONFIGURE_OFFS: rd_val = {24'h0, st_q.cfg};
			CONTROL_OFFS:   rd_val = {24'h0, st_q.half_reload, st_q.reload_rate,
			                          st_q.prescale_buf, st_q.load_okay};
			SOURCE_OFFS:    rd_val = {18'h0, st_q.src_sel, 2'h0, st_q.compare_invert};
			MODULO_OFFS:    rd_val = {17'h0, st_q.mod_buf};
			STATUS_OFFS:    rd_val = {10'h0, st_q.pwm, st_q.down, st_q.cnt};
			LIMIT_OFFS:     rd_val = {st_q.lim_hi, st_q.lim_lo};
			default: begin
				if (APB_REQ_I.paddr >= DUTY_BASE_OFFS && APB_REQ_I.paddr < STATUS_OFFS) begin
					rd_val = {16'h0, st_q.duty_buf[duty_idx[2:0]]};
				end
			end
		endcase
	end

	// -----------------------------------------------------------------
	// Source selection.
	// -----------------------------------------------------------------

	// Sync and reload writes stop when every pair shares one outside source.
	assign bypass_all = (st_q.src_sel[1:0] != SRC_GENERATOR) &&
	                    (st_q.src_sel[1:0] == st_q.src_sel[3:2]) &&
	                    (st_q.src_sel[1:0] == st_q.src_sel[5:4]);

	// Power modes that silence the outputs.
	assign hold_off = MODE_I.stop ||
	                  (MODE_I.wait_mode && !st_q.cfg[CFG_WAIT_BIT]) ||
	                  (MODE_I.debug && !st_q.cfg[CFG_DEBUG_BIT]);

	// Per pair: pick the drive, then pair it up or keep both outputs apart.
	for (genvar p = 0; p < PAIRS; p++) begin : g_pair
		always_comb begin
			unique case (pair_src_e'(st_q.src_sel[2*p +: 2]))
				SRC_GENERATOR: pair_src[p] = cmp[2*p];
				SRC_GPIO:      pair_src[p] = st_q.gpio_s2[p];
				SRC_TIMER:     pair_src[p] = TIMER_I[p];
				SRC_ADC:       pair_src[p] = st_q.adc_drive[p];
			endcase
			if (st_q.cfg[CFG_INDEP_LSB + p]) begin
				drive[2*p]   = pair_src[p];
				drive[2*p+1] = (st_q.src_sel[2*p +: 2] == SRC_GENERATOR) ? cmp[2*p+1]
				                                                          : pair_src[p];
			end else begin
				drive[2*p]   = pair_src[p];
				drive[2*p+1] = !pair_src[p];
			end
		end
	end

	// -----------------------------------------------------------------
	// Counter and reload timing.
	// -----------------------------------------------------------------

	// Next counter value and the reload points it passes.
	always_comb begin
		cnt_n      = st_q.cnt;
		down_n     = st_q.down;
		period_end = 1'b0;
		half_point = 1'b0;
		if (!run) begin
			cnt_n  = 15'h0000;
			down_n = 1'b0;
		end else if (tick) begin
			if (edge_mode) begin
				down_n = 1'b0;
				if (st_q.cnt >= st_q.mod_act || st_q.cnt == 15'h0000) begin
					cnt_n      = 15'h0001;
					period_end = 1'b1;
				end else begin
					cnt_n = st_q.cnt + 15'h0001;
				end
			end else if (!st_q.down) begin
				if (16'(st_q.cnt) + 16'h0001 >= 16'(st_q.mod_act)) begin
					cnt_n      = st_q.mod_act;
					down_n     = 1'b1;
					half_point = 1'b1;
				end else begin
					cnt_n = st_q.cnt + 15'h0001;
				end
			end else begin
				if (st_q.cnt <= 15'h0001) begin
					cnt_n      = 15'h0000;
					down_n     = 1'b0;
					period_end = 1'b1;
				end else begin
					cnt_n = st_q.cnt - 15'h0001;
				end
			end
		end
	end

	// Reload at every Nth boundary, counting half points when asked.
	assign reload = (period_end || (half_point && st_q.half_reload)) &&
	                (st_q.reload_cnt == st_q.reload_rate);

	// -----------------------------------------------------------------
	// Compare outputs.
	// -----------------------------------------------------------------

	// One comparator per channel, all against the shared counter.
	for (genvar c = 0; c < CHANNELS; c++) begin : g_cmp
		assign cmp[c] = compare_out(st_q.duty_act[c], st_q.cnt, st_q.down, edge_mode,
		                            st_q.compare_invert[c]);
	end

	// -----------------------------------------------------------------
	// Next state.
	// -----------------------------------------------------------------

	always_comb begin
		st_d         = st_q;
		st_d.cnt     = cnt_n;
		st_d.down    = down_n;
		st_d.sync    = 1'b0;
		st_d.gpio_s1 = PAIR_GPIO_I;
		st_d.gpio_s2 = st_q.gpio_s1;
		if (rd_setup) begin
			st_d.prdata = mapped ? rd_val : 32'h0000_0000;
		end

		// Converter result against limits, holding between them.
		if (ADC_VALID_I) begin
			for (int p = 0; p < PAIRS; p++) begin
				if (ADC_RESULT_I > st_q.lim_hi) begin
					st_d.adc_drive[p] = 1'b1;
				end else if (ADC_RESULT_I < st_q.lim_lo) begin
					st_d.adc_drive[p] = 1'b0;
				end
			end
		end

		// Reload divider and buffered transfer on load okay.
		if (period_end || (half_point && st_q.half_reload)) begin
			st_d.reload_cnt = reload ? 4'h0 : st_q.reload_cnt + 4'h1;
		end
		if (reload) begin
			st_d.sync = !bypass_all;
			if (st_q.load_okay) begin
				st_d.prescale_act = st_q.prescale_buf;
				st_d.mod_act      = st_q.mod_buf;
				st_d.duty_act     = st_q.duty_buf;
				st_d.load_okay    = 1'b0;
			end
		end
		if (!run) begin
			st_d.reload_cnt = 4'h0;
		end

		// Register writes; a load okay write beats the hardware clear.
		if (wr_en && mapped) begin
			unique case (APB_REQ_I.paddr)
				CONFIGURE_OFFS: st_d.cfg = APB_REQ_I.pwdata[7:0];
				CONTROL_OFFS: begin
					st_d.prescale_buf = APB_REQ_I.pwdata[CTL_PRSC_LSB +: 2];
					st_d.reload_rate  = APB_REQ_I.pwdata[CTL_RATE_LSB +: 4];
					st_d.half_reload  = APB_REQ_I.pwdata[CTL_HALF_BIT];
					if (APB_REQ_I.pwdata[CTL_LOAD_OKAY_BIT]) begin
						st_d.load_okay = 1'b1;
					end
				end
				SOURCE_OFFS: begin
					st_d.compare_invert = APB_REQ_I.pwdata[SRC_INV_LSB +: CHANNELS];
					st_d.src_sel        = APB_REQ_I.pwdata[SRC_SEL_LSB +: 2*PAIRS];
				end
				MODULO_OFFS: begin
					if (!bypass_all) begin
						st_d.mod_buf = APB_REQ_I.pwdata[14:0];
					end
				end
				LIMIT_OFFS: begin
					st_d.lim_lo = APB_REQ_I.pwdata[15:0];
					st_d.lim_hi = APB_REQ_I.pwdata[31:16];
				end
				default: begin
					if (APB_REQ_I.paddr >= DUTY_BASE_OFFS && APB_REQ_I.paddr < STATUS_OFFS
					    && !bypass_all) begin
						st_d.duty_buf[duty_idx[2:0]] = APB_REQ_I.pwdata[15:0];
					end
				end
			endcase
		end

		// Outputs: every source held off until running, silenced in stop, and in wait or debug while CFG_WAIT_BIT or CFG_DEBUG_BIT is clear.
		st_d.pwm = (run && !hold_off) ? drive : '0;
	end

	// -----------------------------------------------------------------
	// State register.
	// -----------------------------------------------------------------

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_q         <= '0;
			st_q.cfg     <= CONFIGURE_RST;
			st_q.mod_buf <= MODULO_RST;
			st_q.mod_act <= MODULO_RST;
			st_q.lim_lo  <= LIMIT_LO_RST;
			st_q.lim_hi  <= LIMIT_HI_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// -----------------------------------------------------------------
	// Outputs.
	// -----------------------------------------------------------------

	assign PWM_O             = st_q.pwm;
	assign SYNC_O            = st_q.sync;
	assign APB_RSP_O.prdata  = st_q.prdata;
	assign APB_RSP_O.pready  = 1'b1;
	assign APB_RSP_O.pslverr = APB_REQ_I.psel && APB_REQ_I.penable && !mapped;

endmodule // pwm_six_channel

// ---- tb/pwm_six_channel_chk.sv ----
`timescale 1ns/10ps

// -----------------------------------------------------------------
// Port-level checker for the six channel modulator.
// -----------------------------------------------------------------
module pwm_six_channel_chk
	import pwm_pkg::*;
#(
	parameter int CHANNELS = 6,
	parameter int PAIRS    = 3
) (
	input wire logic                CLOCK_I,
	input wire logic                RST_N_I,
	input wire apb_req_s            APB_REQ_I,
	input wire apb_rsp_s            APB_RSP_O,
	input wire mode_req_s           MODE_I,
	input wire logic [PAIRS-1:0]    PAIR_GPIO_I,
	input wire logic [PAIRS-1:0]    TIMER_I,
	input wire logic [15:0]         ADC_RESULT_I,
	input wire logic                ADC_VALID_I,
	input wire logic [CHANNELS-1:0] PWM_O,
	input wire logic                SYNC_O
);
	logic [7:0]  cfg_q;
	logic [15:0] src_q;
	logic [4:0]  cmp_cnt_q;
	logic        wr;
	logic        quiet;
	logic        one_src;

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);

	// Decodes writes and the conditions under which pair 0 must be complementary.
	assign wr      = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite && APB_RSP_O.pready;
	assign quiet   = MODE_I == '0 && cfg_q[CFG_RUN_BIT] && !cfg_q[CFG_INDEP_LSB]
		&& src_q[9:8] == SRC_GENERATOR;
	assign one_src = src_q[9:8] != SRC_GENERATOR && src_q[11:10] == src_q[9:8]
		&& src_q[13:12] == src_q[9:8];

	// Shadows the configure and source registers and times a quiet stretch.
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cfg_q     <= CONFIGURE_RST;
			src_q     <= '0;
			cmp_cnt_q <= '0;
		end else begin
			if (wr && APB_REQ_I.paddr == CONFIGURE_OFFS) cfg_q <= APB_REQ_I.pwdata[7:0];
			if (wr && APB_REQ_I.paddr == SOURCE_OFFS) src_q <= APB_REQ_I.pwdata[15:0];
			cmp_cnt_q <= !quiet ? 5'h0 : (cmp_cnt_q == 5'h1f ? cmp_cnt_q : cmp_cnt_q + 5'h1);
		end
	end

	property p_rst_idle;
		$rose(RST_N_I) |-> PWM_O == '0 && !SYNC_O;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("output active after reset");
	property p_stop_idle;
		MODE_I.stop [*3] |-> PWM_O == '0;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("output active in stop");
	property p_wait_idle;
		(MODE_I.wait_mode && !cfg_q[CFG_WAIT_BIT]) [*3] |-> PWM_O == '0;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("output active in wait");
	property p_dbg_idle;
		(MODE_I.debug && !cfg_q[CFG_DEBUG_BIT]) [*3] |-> PWM_O == '0;
	endproperty
	a_dbg_idle: assert property (p_dbg_idle) else $error("output active in debug");
	property p_no_sync;
		one_src [*3] |-> !SYNC_O;
	endproperty
	a_no_sync: assert property (p_no_sync) else $error("sync with one outside source");
	property p_compl;
		cmp_cnt_q == 5'h1f |-> PWM_O[1] != PWM_O[0];
	endproperty
	a_compl: assert property (p_compl) else $error("pair 0 not complementary");
	property p_gpio;
		(src_q[9:8] == SRC_GPIO && !src_q[0] && MODE_I == '0 && cfg_q[CFG_RUN_BIT]
			&& $stable(PAIR_GPIO_I[0])) [*5] |-> PWM_O[0] == PAIR_GPIO_I[0];
	endproperty
	a_gpio: assert property (p_gpio) else $error("pair 0 ignores its pin");
	property p_timer;
		(src_q[9:8] == SRC_TIMER && !src_q[0] && MODE_I == '0 && cfg_q[CFG_RUN_BIT]
			&& $stable(TIMER_I[0])) [*3] |-> PWM_O[0] == TIMER_I[0];
	endproperty
	a_timer: assert property (p_timer) else $error("pair 0 ignores its timer");
	property p_slverr;
		APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.paddr > LIMIT_OFFS |-> APB_RSP_O.pslverr;
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");
endmodule // pwm_six_channel_chk

bind pwm_six_channel pwm_six_channel_chk #(.CHANNELS(CHANNELS), .PAIRS(PAIRS)) u_chk (
	.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .APB_REQ_I(APB_REQ_I), .APB_RSP_O(APB_RSP_O),
	.MODE_I(MODE_I), .PAIR_GPIO_I(PAIR_GPIO_I), .TIMER_I(TIMER_I),
	.ADC_RESULT_I(ADC_RESULT_I), .ADC_VALID_I(ADC_VALID_I), .PWM_O(PWM_O), .SYNC_O(SYNC_O)
);

// ---- tb/gate_drive_model.sv ----
`timescale 1ns/10ps

// -----------------------------------------------------------------
// Gate driver stage of a three-phase inverter bridge.
// -----------------------------------------------------------------
module gate_drive_model (
	input  wire logic       clk_i,
	input  wire logic       clear_i,
	input  wire logic [5:0] gate_i,
	output int              on_cnt_o [6],
	output int              rise_cnt_o,
	output int              overlap_o
);
	logic gate0_q;

	// Counts conduction time per switch, turn-ons of switch 0 and shoot-through of leg 0.
	always_ff @(posedge clk_i) begin
		gate0_q <= gate_i[0];
		for (int i = 0; i < 6; i++) begin
			on_cnt_o[i] <= clear_i ? 0 : on_cnt_o[i] + int'(gate_i[i]);
		end
		rise_cnt_o <= clear_i ? 0 : rise_cnt_o + int'(gate_i[0] && !gate0_q);
		overlap_o  <= clear_i ? 0 : overlap_o + int'(gate_i[0] && gate_i[1]);
	end
endmodule // gate_drive_model

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps

`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end

module tb_top
	import pwm_pkg::*;
;
	logic        clk, rst_n, adc_vld, sync, clr, serr;
	apb_req_s    req;
	apb_rsp_s    rsp;
	mode_req_s   mode;
	logic [2:0]  gpio, tmr;
	logic [15:0] adc;
	logic [5:0]  pwm;
	logic [31:0] rdat;
	int          on_cnt [6];
	int          rise, ovl, n_sync, num_errors, n_checks, cyc;

	pwm_six_channel u_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .APB_REQ_I(req), .APB_RSP_O(rsp),
		.MODE_I(mode), .PAIR_GPIO_I(gpio), .TIMER_I(tmr), .ADC_RESULT_I(adc),
		.ADC_VALID_I(adc_vld), .PWM_O(pwm), .SYNC_O(sync));
	gate_drive_model u_gate (.clk_i(clk), .clear_i(clr), .gate_i(pwm), .on_cnt_o(on_cnt),
		.rise_cnt_o(rise), .overlap_o(ovl));

	// ---------------------------------------------------------
	// Clock, sync pulse count and hang guard.
	// ---------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Counts sync pulses over the same window as the gate model.
	always @(posedge clk) n_sync <= clr ? 0 : n_sync + int'(sync === 1'b1);
	// Stops a hung run.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One APB transfer; read data and error flag are taken at the edge that ends the access.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (rsp.pready !== 1'b1);
		rdat = rsp.prdata;
		serr = rsp.pslverr;
		req <= '0;
	endtask

	task automatic prog(input logic [7:0] c, input logic [15:0] s, input logic [14:0] m,
			input logic [15:0] d0, input logic [15:0] d1, input logic [7:0] k);
		xfer(1'b1, SOURCE_OFFS, {16'h0, s});
		xfer(1'b1, MODULO_OFFS, {17'h0, m});
		xfer(1'b1, DUTY_BASE_OFFS, {16'h0, d0});
		xfer(1'b1, DUTY_BASE_OFFS + 8'h04, {16'h0, d1});
		xfer(1'b1, CONTROL_OFFS, {24'h0, k});
		xfer(1'b1, CONFIGURE_OFFS, {24'h0, c});
		repeat (80) @(posedge clk);
	endtask

	// Collects n cycles of gate activity, ending at a falling edge.
	task automatic meas(input int n);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// ---------------------------------------------------------
	// Scenarios.
	// ---------------------------------------------------------
	task automatic t_reset();
		`CHK({pwm, sync}, 7'h00);
		xfer(1'b0, CONFIGURE_OFFS, 32'h0);
		`CHK(rdat, {24'h0, CONFIGURE_RST});
		xfer(1'b0, LIMIT_OFFS, 32'h0);
		`CHK(rdat, {LIMIT_HI_RST, LIMIT_LO_RST});
		xfer(1'b0, STATUS_OFFS, 32'h0);
		`CHK(rdat, 32'h0000_0000);
		xfer(1'b0, 8'h30, 32'h0);
		`CHK({serr, rdat}, 33'h100000000);
		meas(40);
		`CHK(on_cnt[0] + on_cnt[1] + rise, 0);
	endtask

	task automatic t_edge();
		prog(8'h83, 16'h0, 15'h4, 16'h2, 16'h0, 8'h01);
		meas(40);
		`CHK({on_cnt[0], on_cnt[1], rise}, {32'd20, 32'd20, 32'd10});
		`CHK(ovl, 0);
		`CHK(n_sync, 10);
		prog(8'h83, 16'h0, 15'h4, 16'h2, 16'h0, 8'h09);
		meas(40);
		`CHK(n_sync, 5);
		prog(8'h83, 16'h0, 15'h4, 16'h2, 16'h0, 8'h79);
		meas(128);
		`CHK(n_sync, 2);
	endtask

	task automatic t_duty();
		logic [15:0] dv [7];
		int          ex [7];
		dv = '{16'hffff, 16'h8000, 16'h0, 16'h1, 16'h3, 16'h4, 16'h9};
		ex = '{0, 0, 0, 10, 30, 40, 40};
		for (int i = 0; i < 7; i++) begin
			prog(8'h83, 16'h0, 15'h4, dv[i], 16'h0, 8'h01);
			meas(40);
			`CHK(on_cnt[0], ex[i]);
			`CHK(on_cnt[1], 40 - ex[i]);
		end
	endtask

	task automatic t_shape();
		prog(8'h81, 16'h0, 15'h4, 16'h1, 16'h0, 8'h81);
		meas(40);
		`CHK({on_cnt[0], rise, n_sync}, {32'd10, 32'd5, 32'd10});
		prog(8'h83, 16'h1, 15'h4, 16'h1, 16'h0, 8'h01);
		meas(40);
		`CHK({on_cnt[0], on_cnt[1]}, {32'd30, 32'd10});
		prog(8'h87, 16'h0, 15'h4, 16'h1, 16'h3, 8'h01);
		meas(40);
		`CHK({on_cnt[0], on_cnt[1]}, {32'd10, 32'd30});
	endtask

	task automatic t_clock();
		logic [7:0] cf [4];
		logic [7:0] kk [4];
		int         nn [4];
		cf = '{8'h83, 8'h83, 8'h83, 8'h03};
		kk = '{8'h02, 8'h03, 8'h07, 8'h01};
		nn = '{80, 80, 160, 120};
		for (int i = 0; i < 4; i++) begin
			prog(cf[i], 16'h0, 15'h4, 16'h2, 16'h0, kk[i]);
			meas(nn[i]);
			`CHK(rise, i == 0 ? 20 : (i == 2 ? 5 : 10));
		end
	endtask

	task automatic t_modes();
		for (int i = 0; i < 6; i++) begin
			prog(i < 3 ? 8'h83 : 8'he3, 16'h0, 15'h4, 16'h2, 16'h0, 8'h01);
			mode <= mode_req_s'(3'b100 >> (i % 3));
			meas(40);
			`CHK(on_cnt[0] + on_cnt[1], i < 4 ? 0 : 40);
			@(posedge clk);
			mode <= '0;
			meas(40);
			`CHK(on_cnt[0] + on_cnt[1], 40);
		end
	endtask

	task automatic t_src();
		prog(8'h83, 16'h1500, 15'h4, 16'h2, 16'h0, 8'h01);
		gpio <= 3'b101;
		xfer(1'b1, MODULO_OFFS, 32'h7);
		xfer(1'b0, MODULO_OFFS, 32'h0);
		`CHK(rdat, 32'h4);
		meas(40);
		`CHK({n_sync, pwm}, {32'd0, 6'b011001});
		prog(8'h83, 16'h0200, 15'h4, 16'h2, 16'h0, 8'h01);
		tmr <= 3'b001;
		meas(8);
		`CHK(pwm[1:0], 2'b01);
		prog(8'h83, 16'h0300, 15'h4, 16'h2, 16'h0, 8'h01);
		xfer(1'b1, LIMIT_OFFS, 32'h08000100);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			adc <= i == 0 ? 16'h0900 : 16'h0050;
			adc_vld <= 1'b1;
			@(posedge clk);
			adc_vld <= 1'b0;
			meas(8);
			`CHK(pwm[1:0], i == 0 ? 2'b01 : 2'b10);
		end
	endtask

	// Main sequence.
	initial begin
		{rst_n, adc_vld, clr, gpio, tmr, adc} = '0;
		req = '0;
		mode = '0;
		{num_errors, n_checks, cyc, n_sync} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		t_reset();
		t_edge();
		t_duty();
		t_shape();
		t_clock();
		t_modes();
		t_src();
		summarize();
	end
endmodule // tb_top
